// file: common/cfs_params.svh
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH
// Register addresses
`define CFS_ADDR_FAULT       8'h09
`define CFS_ADDR_STATUS      8'h0a
`define CFS_ADDR_RSTID       8'h0b
// Fault register fields
`define CFS_FLT_TIMER_BIT    7
`define CFS_FLT_BOOST_BIT    6
`define CFS_FLT_CODE_HI      5
`define CFS_FLT_CODE_LO      4
`define CFS_FLT_CELL_OV_BIT  3
`define CFS_FLT_ZONE_HI      2
// Status register fields
`define CFS_ST_GOOD_BIT      7
`define CFS_ST_VLIM_BIT      6
`define CFS_ST_ILIM_BIT      5
`define CFS_ST_FINISH_BIT    3
`define CFS_ST_ACOV_BIT      2
`define CFS_ST_VMASK_BIT     1
`define CFS_ST_IMASK_BIT     0
// Reset and identification fields
`define CFS_RST_BIT          7
`define CFS_ID_HI            6
`define CFS_ID_LO            3
`define CFS_MAKER_BIT        2
// Reset values of writable bits
`define CFS_MASK_RESET       1'b0
// Input fault threshold in millivolts
`define CFS_INPUT_LOW_MV     16'd3800
`endif

// file: common/cfs_pkg.sv
package cfs_pkg;
  // Charge fault codes
  typedef enum logic [1:0] {
    CFS_CHG_NORMAL  = 2'h0,
    CFS_CHG_INPUT   = 2'h1,
    CFS_CHG_THERMAL = 2'h2,
    CFS_CHG_TIMER   = 2'h3
  } cfs_charge_code_t;
  // Thermistor zone codes
  typedef enum logic [2:0] {
    CFS_ZONE_NORMAL = 3'h0,
    CFS_ZONE_WARM   = 3'h2,
    CFS_ZONE_COOL   = 3'h3,
    CFS_ZONE_COLD   = 3'h5,
    CFS_ZONE_HOT    = 3'h6
  } cfs_zone_t;
  // Settings reset sequencer states, one-hot
  typedef enum logic [1:0] {
    CFS_RS_IDLE = 2'b01,
    CFS_RS_BUSY = 2'b10
  } cfs_rst_state_t;
endpackage

// file: logic/cfs_fault_encode.sv
`timescale 1ns/1ps
// Encodes charge fault code and thermistor zone from live conditions
module cfs_fault_encode (
  // Charge conditions
  input  wire logic                      input_ov,
  input  wire logic [15:0]               input_mv,
  input  wire logic [15:0]               cell_mv,
  input  wire logic                      thermal_shutdown,
  input  wire logic                      safety_timer_expired,
  // Thermistor conditions
  input  wire logic                      therm_hot,
  input  wire logic                      therm_warm,
  input  wire logic                      therm_cool,
  input  wire logic                      therm_cold,
  input  wire logic                      buck_mode,
  // Codes
  output cfs_pkg::cfs_charge_code_t      charge_fault_code,
  output cfs_pkg::cfs_zone_t             thermistor_zone_code
);
`include "cfs_params.svh"
  logic input_fault;

  // [RL5] input fault detect
  assign input_fault = input_ov ||
                       ((input_mv > cell_mv) && (input_mv < `CFS_INPUT_LOW_MV));

  // [RL4] charge code priority
  always_comb
  begin
    if (input_fault)
      charge_fault_code = cfs_pkg::CFS_CHG_INPUT;
    else if (thermal_shutdown)
      charge_fault_code = cfs_pkg::CFS_CHG_THERMAL;
    else if (safety_timer_expired)
      charge_fault_code = cfs_pkg::CFS_CHG_TIMER;
    else
      charge_fault_code = cfs_pkg::CFS_CHG_NORMAL;
  end

  // [RL7] zone encoding
  always_comb
  begin
    if (therm_hot)
      thermistor_zone_code = cfs_pkg::CFS_ZONE_HOT;
    else if (therm_cold)
      thermistor_zone_code = cfs_pkg::CFS_ZONE_COLD;
    else if (therm_warm)
      thermistor_zone_code = cfs_pkg::CFS_ZONE_WARM;
    else if (therm_cool && buck_mode)  // Cool only reported in buck mode
      thermistor_zone_code = cfs_pkg::CFS_ZONE_COOL;
    else
      thermistor_zone_code = cfs_pkg::CFS_ZONE_NORMAL;
  end
endmodule // cfs_fault_encode

// file: logic/cfs_irq_gate.sv
`timescale 1ns/1ps
// Rising-edge pulse on a regulation status, gated by its mask
module cfs_irq_gate (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Event and mask
  input  wire logic active,
  input  wire logic mask,
  // Pulse
  output logic      pulse
);
  logic prev_q;
  logic prev_d;

  // Previous level
  always_comb
  begin
    prev_d = active;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      prev_q <= 1'b0;
    else
      prev_q <= prev_d;
  end

  // Mask of 1 suppresses the pulse
  assign pulse = active && !prev_q && !mask;
endmodule // cfs_irq_gate

// file: logic/cfs_regs.sv
`timescale 1ns/1ps
// What this block does
// [RL1] Fault register at 0x09 is read-only; host writes do nothing.
// [RL2] Fault bit 7 shows supervisor timer expiry.
// [RL3] Fault bit 6 shows boost start prevented by overload, input OV or low cell.
// [RL4] Fault bits 5:4: 00 normal, 01 input, 10 thermal, 11 safety timer.
// [RL5] Input fault when input OV, or cell below input below 3.8V.
// [RL6] Fault bit 3 shows cell over-voltage while detected.
// [RL7] Fault bits 2:0: 010 warm, 011 cool in buck, 101 cold, 110 hot.
// [RL8] Thermistor zone follows live condition; no read needed to clear.
// [RL9] Status register at 0x0A mixes live read-only bits and writable masks.
// [RL10] Status bit 7 shows a good input source attached.
// [RL11] Status bit 6 shows input voltage limit loop active.
// [RL12] Status bit 5 shows input current limit loop active.
// [RL13] Status bit 3 shows finish timer counting.
// [RL14] Status bit 2 shows adapter over-voltage.
// [RL15] Status bit 1 masks voltage-limit interrupt pulse; default 0, reset clears.
// [RL16] Status bit 0 masks current-limit interrupt pulse; default 0, reset clears.
// [RL17] Writing 1 to bit 7 of 0x0B restores defaults and restarts safety timer.
// [RL18] The register reset bit clears itself when the settings reset finishes.
// [RL19] 0x0B holds read-only part id in 6:3 and revision in 1:0.
// [RL20] Writes to read-only or reserved bits are ignored, writable bits kept.
module cfs_regs #(
  parameter logic [3:0] PART_ID  = 4'h5,  // Arbitrary value
  parameter logic [1:0] REVISION = 2'h1,  // Arbitrary value
  parameter logic       MAKER    = 1'b1   // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Register access from the serial engine
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Fault sources
  input  wire logic       supervisor_expired,
  input  wire logic       boost_overload,
  input  wire logic       cell_low_for_boost,
  input  wire logic       input_ov,
  input  wire logic [15:0] input_mv,
  input  wire logic [15:0] cell_mv,
  input  wire logic       thermal_shutdown,
  input  wire logic       safety_timer_expired,
  input  wire logic       cell_overvoltage,
  input  wire logic       therm_hot,
  input  wire logic       therm_warm,
  input  wire logic       therm_cool,
  input  wire logic       therm_cold,
  input  wire logic       buck_mode,
  // Status sources
  input  wire logic       input_source_good,
  input  wire logic       input_voltage_limit_active,
  input  wire logic       input_current_limit_active,
  input  wire logic       finish_timer_running,
  input  wire logic       adapter_overvoltage_flag,
  // Settings reset handshake with other register groups
  input  wire logic       settings_reset_done,
  output logic            settings_reset,
  output logic            safety_timer_restart,
  // Interrupt pulses to the interrupt pin logic
  output logic            voltage_limit_irq,
  output logic            current_limit_irq
);
`include "cfs_params.svh"
  cfs_pkg::cfs_charge_code_t charge_fault_code;
  cfs_pkg::cfs_zone_t        thermistor_zone_code;
  cfs_pkg::cfs_rst_state_t   rs_state_q;
  cfs_pkg::cfs_rst_state_t   rs_state_d;
  logic       voltage_limit_irq_mask_q;
  logic       voltage_limit_irq_mask_d;
  logic       current_limit_irq_mask_q;
  logic       current_limit_irq_mask_d;
  logic       timer_restart_q;
  logic       timer_restart_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] fault_flags;
  logic [7:0] input_status_and_masks;
  logic [7:0] reset_and_identification;
  logic       rst_request;

  // Fault code encoders
  cfs_fault_encode u_encode (
    .input_ov             (input_ov),
    .input_mv             (input_mv),
    .cell_mv              (cell_mv),
    .thermal_shutdown     (thermal_shutdown),
    .safety_timer_expired (safety_timer_expired),
    .therm_hot            (therm_hot),
    .therm_warm           (therm_warm),
    .therm_cool           (therm_cool),
    .therm_cold           (therm_cold),
    .buck_mode            (buck_mode),
    .charge_fault_code    (charge_fault_code),
    .thermistor_zone_code (thermistor_zone_code)
  );

  // Fault register image, all live
  always_comb
  begin
    fault_flags = 8'h00;
    // [RL2] timer expiry bit
    fault_flags[`CFS_FLT_TIMER_BIT] = supervisor_expired;
    // [RL3] boost start blocked
    fault_flags[`CFS_FLT_BOOST_BIT] = boost_overload || input_ov || cell_low_for_boost;
    // [RL4] charge code field
    fault_flags[`CFS_FLT_CODE_HI:`CFS_FLT_CODE_LO] = charge_fault_code;
    // [RL6] cell overvoltage bit
    fault_flags[`CFS_FLT_CELL_OV_BIT] = cell_overvoltage;
    // [RL8] live zone field
    fault_flags[`CFS_FLT_ZONE_HI:0] = thermistor_zone_code;
  end

  // Status register image
  always_comb
  begin
    input_status_and_masks = 8'h00;  // Reserved bit 4 reads 0
    // [RL10] input good bit
    input_status_and_masks[`CFS_ST_GOOD_BIT] = input_source_good;
    // [RL11] voltage loop bit
    input_status_and_masks[`CFS_ST_VLIM_BIT] = input_voltage_limit_active;
    // [RL12] current loop bit
    input_status_and_masks[`CFS_ST_ILIM_BIT] = input_current_limit_active;
    // [RL13] finish timer bit
    input_status_and_masks[`CFS_ST_FINISH_BIT] = finish_timer_running;
    // [RL14] adapter OV bit
    input_status_and_masks[`CFS_ST_ACOV_BIT] = adapter_overvoltage_flag;
    input_status_and_masks[`CFS_ST_VMASK_BIT] = voltage_limit_irq_mask_q;
    input_status_and_masks[`CFS_ST_IMASK_BIT] = current_limit_irq_mask_q;
  end

  // Reset and identification image
  always_comb
  begin
    reset_and_identification = 8'h00;
    reset_and_identification[`CFS_RST_BIT] = (rs_state_q == cfs_pkg::CFS_RS_BUSY);
    // [RL19] identification fields
    reset_and_identification[`CFS_ID_HI:`CFS_ID_LO] = PART_ID;
    reset_and_identification[`CFS_MAKER_BIT] = MAKER;
    reset_and_identification[1:0] = REVISION;
  end

  // [RL17] reset request decode
  assign rst_request = reg_wr && (reg_addr == `CFS_ADDR_RSTID) && reg_wdata[`CFS_RST_BIT];

  // Settings reset sequencer
  always_comb
  begin
    rs_state_d = rs_state_q;
    timer_restart_d = 1'b0;
    case (rs_state_q)
      cfs_pkg::CFS_RS_IDLE:
        if (rst_request)
        begin
          rs_state_d = cfs_pkg::CFS_RS_BUSY;
          // [RL17] restart safety timer
          timer_restart_d = 1'b1;
        end
      cfs_pkg::CFS_RS_BUSY:
        // [RL18] self clearing bit
        if (settings_reset_done)
          rs_state_d = cfs_pkg::CFS_RS_IDLE;
      default:
        rs_state_d = cfs_pkg::CFS_RS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rs_state_q      <= cfs_pkg::CFS_RS_IDLE;
      timer_restart_q <= 1'b0;
    end
    else
    begin
      rs_state_q      <= rs_state_d;
      timer_restart_q <= timer_restart_d;
    end
  end

  assign settings_reset       = (rs_state_q == cfs_pkg::CFS_RS_BUSY);
  assign safety_timer_restart = timer_restart_q;

  // Mask bits: write at 0x0A, default on settings reset
  always_comb
  begin
    voltage_limit_irq_mask_d = voltage_limit_irq_mask_q;
    current_limit_irq_mask_d = current_limit_irq_mask_q;
    // [RL15] [RL16] restore mask defaults
    if (settings_reset)
    begin
      voltage_limit_irq_mask_d = `CFS_MASK_RESET;
      current_limit_irq_mask_d = `CFS_MASK_RESET;
    end
    // [RL20] only mask bits taken
    else if (reg_wr && (reg_addr == `CFS_ADDR_STATUS))
    begin
      voltage_limit_irq_mask_d = reg_wdata[`CFS_ST_VMASK_BIT];
      current_limit_irq_mask_d = reg_wdata[`CFS_ST_IMASK_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      voltage_limit_irq_mask_q <= `CFS_MASK_RESET;
      current_limit_irq_mask_q <= `CFS_MASK_RESET;
    end
    else
    begin
      voltage_limit_irq_mask_q <= voltage_limit_irq_mask_d;
      current_limit_irq_mask_q <= current_limit_irq_mask_d;
    end
  end

  // [RL15] voltage limit pulse gate
  cfs_irq_gate u_vgate (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .active  (input_voltage_limit_active),
    .mask    (voltage_limit_irq_mask_q),
    .pulse   (voltage_limit_irq)
  );

  // [RL16] current limit pulse gate
  cfs_irq_gate u_igate (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .active  (input_current_limit_active),
    .mask    (current_limit_irq_mask_q),
    .pulse   (current_limit_irq)
  );

  // Read data, registered on a read strobe; unmapped reads give zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      // [RL1] fault register readback
      if (reg_addr == `CFS_ADDR_FAULT)
        rdata_d = fault_flags;
      // [RL9] status register readback
      else if (reg_addr == `CFS_ADDR_STATUS)
        rdata_d = input_status_and_masks;
      else if (reg_addr == `CFS_ADDR_RSTID)
        rdata_d = reset_and_identification;
      else
        rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;
endmodule // cfs_regs

// file: sim/cfs_peer_model.sv
`timescale 1ns/1ps
// Other register groups: acknowledge a settings reset after a delay
module cfs_peer_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Handshake
  input  wire logic settings_reset,
  input  wire logic slow,
  output logic      settings_reset_done
);
  logic [3:0] wait_q;
  // Count busy cycles, answer once with a one-cycle done
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_q              <= 4'h0;
      settings_reset_done <= 1'b0;
    end
    else
    begin
      wait_q              <= settings_reset ? wait_q + 4'h1 : 4'h0;
      settings_reset_done <= settings_reset && !settings_reset_done
                             && (wait_q >= (slow ? 4'h6 : 4'h1));
    end
  end
endmodule // cfs_peer_model

// file: sim/cfs_regs_asserts.sv
`timescale 1ns/1ps
// Port checks for the register bank
module cfs_regs_asserts #(
  parameter logic [3:0] PART_ID  = 4'h5,
  parameter logic [1:0] REVISION = 2'h1,
  parameter logic       MAKER    = 1'b1
) (
  // Clock, reset and bus
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Sources
  input wire logic       supervisor_expired,
  input wire logic       cell_overvoltage,
  input wire logic       input_voltage_limit_active,
  input wire logic       input_current_limit_active,
  // Reset handshake and pulses
  input wire logic       settings_reset_done,
  input wire logic       settings_reset,
  input wire logic       safety_timer_restart,
  input wire logic       voltage_limit_irq,
  input wire logic       current_limit_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  AST_FLT_TIMER: assert property (
    reg_rd && reg_addr == 8'h09 |=> reg_rdata[7] == $past(supervisor_expired))
    else $error("fault bit 7 wrong");
  AST_FLT_CELL: assert property (
    reg_rd && reg_addr == 8'h09 |=> reg_rdata[3] == $past(cell_overvoltage))
    else $error("fault bit 3 wrong");
  AST_ID: assert property (
    reg_rd && reg_addr == 8'h0b |=> reg_rdata[6:0] == {PART_ID, MAKER, REVISION})
    else $error("identity bits wrong");
  AST_VIRQ: assert property (
    voltage_limit_irq |-> input_voltage_limit_active && !$past(input_voltage_limit_active))
    else $error("voltage pulse without a rise");
  AST_IIRQ: assert property (
    current_limit_irq |-> input_current_limit_active && !$past(input_current_limit_active))
    else $error("current pulse without a rise");
  AST_RST_GO: assert property (
    reg_wr && reg_addr == 8'h0b && reg_wdata[7] && !settings_reset
    |=> settings_reset && safety_timer_restart)
    else $error("reset write not taken");
  AST_RESTART_ONE: assert property (
    safety_timer_restart |=> !safety_timer_restart)
    else $error("restart pulse too long");
  AST_RST_END: assert property (
    settings_reset && settings_reset_done |=> !settings_reset)
    else $error("reset bit did not clear");
endmodule // cfs_regs_asserts

bind cfs_regs cfs_regs_asserts #(
  .PART_ID(PART_ID), .REVISION(REVISION), .MAKER(MAKER)
) u_chk (
  .clk_sys                    (clk_sys),
  .arst_n                     (arst_n),
  .reg_wr                     (reg_wr),
  .reg_rd                     (reg_rd),
  .reg_addr                   (reg_addr),
  .reg_wdata                  (reg_wdata),
  .reg_rdata                  (reg_rdata),
  .supervisor_expired         (supervisor_expired),
  .cell_overvoltage           (cell_overvoltage),
  .input_voltage_limit_active (input_voltage_limit_active),
  .input_current_limit_active (input_current_limit_active),
  .settings_reset_done        (settings_reset_done),
  .settings_reset             (settings_reset),
  .safety_timer_restart       (safety_timer_restart),
  .voltage_limit_irq          (voltage_limit_irq),
  .current_limit_irq          (current_limit_irq)
);

// file: sim/tb_cfs_regs.sv
`timescale 1ns/1ps
// Self-checking bench for the charger register bank
module tb_cfs_regs;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [16:0] src = '0;
  logic [15:0] input_mv = 16'd5000;
  logic [15:0] cell_mv = 16'd3700;
  logic [1:0]  mask = 2'h0;
  logic        slow = 1'b0;
  logic        done, srst, rstr, virq, iirq, vprev, iprev;
  logic [31:0] x = 32'd60;
  int          fail_count = 0;
  int          n_tests = 0;

  always #2.5 clk_sys = ~clk_sys;

  cfs_regs u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supervisor_expired(src[0]), .boost_overload(src[1]), .cell_low_for_boost(src[2]),
    .input_ov(src[3]), .input_mv(input_mv), .cell_mv(cell_mv), .thermal_shutdown(src[4]),
    .safety_timer_expired(src[5]), .cell_overvoltage(src[6]), .therm_hot(src[7]),
    .therm_warm(src[8]), .therm_cool(src[9]), .therm_cold(src[10]), .buck_mode(src[11]),
    .input_source_good(src[12]), .input_voltage_limit_active(src[13]),
    .input_current_limit_active(src[14]), .finish_timer_running(src[15]),
    .adapter_overvoltage_flag(src[16]), .settings_reset_done(done),
    .settings_reset(srst), .safety_timer_restart(rstr),
    .voltage_limit_irq(virq), .current_limit_irq(iirq));

  cfs_peer_model u_peer (.clk_sys(clk_sys), .arst_n(arst_n), .settings_reset(srst),
    .slow(slow), .settings_reset_done(done));

  // Random source
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected fault image, input fault first, hot zone first
  function automatic logic [7:0] exp_fault();
    logic [1:0] c;
    logic [2:0] z;
    c = (src[3] || (input_mv > cell_mv && input_mv < 16'd3800)) ? 2'h1
      : src[4] ? 2'h2 : src[5] ? 2'h3 : 2'h0;
    z = src[7] ? 3'h6 : src[10] ? 3'h5 : src[8] ? 3'h2 : (src[9] && src[11]) ? 3'h3 : 3'h0;
    return {src[0], src[1] | src[2] | src[3], c, src[6], z};
  endfunction

  // Expected status image, reserved bit low
  function automatic logic [7:0] exp_status();
    return {src[12], src[13], src[14], 1'b0, src[15], src[16], mask};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One write strobe, held until the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // One read strobe, data compared once registered
  task automatic rdc(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, want);
  endtask

  // Bounded wait for the settings reset to finish
  task automatic wait_idle();
    for (int i = 0; i < 30; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (srst === 1'b0)
        return;
    end
    fail_count++;
    close_out();
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdc(8'h0a, 8'h00);
    rdc(8'h0b, 8'h2d);
    // Random sources, with threshold corners first
    for (int k = 0; k < 60; k++)
    begin
      x = xs(x);
      vprev = src[13];
      iprev = src[14];
      @(posedge clk_sys);
      src <= x[16:0];
      input_mv <= (k < 3) ? 16'd3798 + 16'(k) : 16'd3000 + {4'h0, x[27:16]};
      cell_mv <= (k < 3) ? 16'd3797 : 16'd3000 + {6'h0, x[31:22]};
      #1;
      check({7'h0, virq}, {7'h0, src[13] & ~vprev & ~mask[1]});
      check({7'h0, iirq}, {7'h0, src[14] & ~iprev & ~mask[0]});
      wr(8'h09, x[7:0]);
      wr(8'h0a, x[15:8]);
      mask = x[9:8];
      rdc(8'h09, exp_fault());
      rdc(8'h0a, exp_status());
      rdc(8'h0b, 8'h2d);
      rdc({2'h3, x[5:0]}, 8'h00);
    end
    // Register reset, prompt and slow acknowledge
    for (int s = 0; s < 2; s++)
    begin
      slow <= s[0];
      wr(8'h0a, 8'h03);
      mask = 2'h3;
      wr(8'h0b, 8'h00);
      rdc(8'h0a, exp_status());
      wr(8'h0b, 8'hff);
      #1;
      check({7'h0, rstr}, 8'h01);
      rdc(8'h0b, 8'had);
      mask = 2'h0;
      // Slow peer is still busy here: the reset must beat this mask write
      if (s == 1)
        wr(8'h0a, 8'h03);
      wait_idle();
      rdc(8'h0a, exp_status());
      rdc(8'h0b, 8'h2d);
    end
    close_out();
  end
endmodule // tb_cfs_regs
